// ==== design/scm_pkg.sv ====
package scm_pkg;
  // stabilization select field: overflow after 2^(base+sel) main clocks
  localparam int STAB_SEL_W = 3;
  localparam logic [2:0] STAB_SEL_RST = 3'h5;
  localparam int STAB_BASE_EXP = 10;
  localparam int STAB_RST_EXP = 15;
  localparam int WDT_CNT_W = 20;
  localparam int DIV_W = 3;
  localparam int N_TMR8 = 2;
  localparam int N_CSI = 3;
  localparam int CLK_HZ = 25000000;
  // clock mode stays this many cycles in the switch state before entering subclock mode
  localparam int CLKSW_SYNC = 2;
endpackage

// ==== design/scm_clock_ctrl.sv ====
`timescale 1ns/1ps
module scm_clock_ctrl #(
  parameter int N_TMR8 = scm_pkg::N_TMR8,
  parameter int N_CSI = scm_pkg::N_CSI
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic stop_enter,
  input wire logic stop_wake_irq,
  input wire logic [scm_pkg::STAB_SEL_W-1:0] stab_time_select_reg,
  input wire logic subclock_select_bit,
  input wire logic main_osc_stop_bit,
  input wire logic [scm_pkg::DIV_W-1:0] cpu_clock_divider_field,
  input wire logic wdt1_run,
  input wire logic wdt1_clear,
  input wire logic [N_TMR8-1:0] timer8_ext_clock_sel,
  input wire logic interval_timer_h_one_subclk_sel,
  input wire logic watch_subclk_sel,
  input wire logic wdt2_subclk_sel,
  input wire logic [N_CSI-1:0] csi_ext_clock_sel,
  input wire logic uart0_ext_baud_sel,
  output logic subclock_status_bit,
  output logic sys_clk_sel_sub,
  output logic main_osc_en,
  output logic in_stop,
  output logic stab_wait,
  output logic cpu_run,
  output logic [scm_pkg::DIV_W-1:0] cpu_div_out,
  output logic [scm_pkg::WDT_CNT_W-1:0] wdt1_count,
  output logic wdt1_overflow,
  output logic main_periph_en,
  output logic [N_TMR8-1:0] timer8_en,
  output logic interval_timer_h_one_en,
  output logic watch_en,
  output logic wdt2_en,
  output logic [N_CSI-1:0] csi_en,
  output logic uart0_en
);
  typedef enum logic [1:0] {
    SCM_RUN,
    SCM_STOP,
    SCM_STAB
  } scm_pwr_e;

  typedef enum logic [1:0] {
    SCM_NORMAL,
    SCM_SWITCH,
    SCM_SUB
  } scm_clk_e;

  localparam int CW = scm_pkg::WDT_CNT_W;
  localparam int DW = scm_pkg::DIV_W;

  // synchroniser stages for the pin and the wake request
  logic rpin_meta_r;
  logic rpin_meta_nxt;
  logic rpin_sync_r;
  logic rpin_sync_nxt;
  logic rpin_prev_r;
  logic rpin_prev_nxt;
  logic wake_meta_r;
  logic wake_meta_nxt;
  logic wake_sync_r;
  logic wake_sync_nxt;
  logic rpin_fall;

  // power state and the overflow exponent it waits on
  scm_pwr_e pwr_r;
  scm_pwr_e pwr_nxt;
  logic [4:0] ovf_exp_r;
  logic [4:0] ovf_exp_nxt;
  logic [4:0] prog_exp;

  // clock mode, switch delay and oscillator stop
  scm_clk_e clk_r;
  scm_clk_e clk_nxt;
  logic [1:0] sw_cnt_r;
  logic [1:0] sw_cnt_nxt;
  logic osc_stop_r;
  logic osc_stop_nxt;

  // shared watchdog 1 counter
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] ovf_mask;
  logic cnt_at_ovf;
  logic ovf_r;
  logic ovf_nxt;

  // registered copy of the divider field
  logic [DW-1:0] div_r;
  logic [DW-1:0] div_nxt;

  // main clock is stopped only while in subclock mode
  logic main_stopped;

  // pin and wake inputs come from other domains
  always_comb begin
    rpin_meta_nxt = reset_pin_n;
    rpin_sync_nxt = rpin_meta_r;
    rpin_prev_nxt = rpin_sync_r;
    wake_meta_nxt = stop_wake_irq;
    wake_sync_nxt = wake_meta_r;
  end

  // pin stages reset to the idle high level, so no false edge after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rpin_meta_r <= 1'h1;
      rpin_sync_r <= 1'h1;
      rpin_prev_r <= 1'h1;
      wake_meta_r <= 1'h0;
      wake_sync_r <= 1'h0;
    end else begin
      rpin_meta_r <= rpin_meta_nxt;
      rpin_sync_r <= rpin_sync_nxt;
      rpin_prev_r <= rpin_prev_nxt;
      wake_meta_r <= wake_meta_nxt;
      wake_sync_r <= wake_sync_nxt;
    end
  end

  // the second and third stages feed the edge detector
  assign rpin_fall = rpin_prev_r & ~rpin_sync_r;

  // programmed exponent, base plus select
  assign prog_exp = 5'(scm_pkg::STAB_BASE_EXP) + 5'(stab_time_select_reg);

  // low bits that must all be set for an overflow
  assign ovf_mask = CW'((64'h1 << ovf_exp_r) - 64'h1);
  assign cnt_at_ovf = (cnt_r & ovf_mask) == ovf_mask;

  // power state: run, stop, stabilization wait
  always_comb begin
    pwr_nxt = pwr_r;
    ovf_exp_nxt = ovf_exp_r;
    case (pwr_r)
      SCM_RUN: begin
        // running overflow follows the programmed select
        ovf_exp_nxt = prog_exp;
        if (stop_enter && !rpin_fall) begin
          pwr_nxt = SCM_STOP;
        end
      end
      SCM_STOP: begin
        if (rpin_fall) begin
          ovf_exp_nxt = 5'(scm_pkg::STAB_RST_EXP);
          pwr_nxt = SCM_STAB;
        end else if (wake_sync_r) begin
          ovf_exp_nxt = prog_exp;
          pwr_nxt = SCM_STAB;
        end
      end
      SCM_STAB: begin
        if (cnt_at_ovf) begin
          pwr_nxt = SCM_RUN;
        end
      end
      default: begin
        pwr_nxt = SCM_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_r <= SCM_RUN;
      ovf_exp_r <= 5'(scm_pkg::STAB_RST_EXP);
    end else begin
      pwr_r <= pwr_nxt;
      ovf_exp_r <= ovf_exp_nxt;
    end
  end

  // clock mode: normal, switching, subclock
  always_comb begin
    clk_nxt = clk_r;
    sw_cnt_nxt = 2'h0;
    osc_stop_nxt = osc_stop_r;
    case (clk_r)
      SCM_NORMAL: begin
        osc_stop_nxt = 1'h0;
        if (subclock_select_bit && pwr_r == SCM_RUN) begin
          clk_nxt = SCM_SWITCH;
        end
      end
      SCM_SWITCH: begin
        // switch delay lets the subclock path settle first
        sw_cnt_nxt = sw_cnt_r + 2'h1;
        if (!subclock_select_bit) begin
          clk_nxt = SCM_NORMAL;
        end else if (sw_cnt_r == 2'(scm_pkg::CLKSW_SYNC - 1)) begin
          clk_nxt = SCM_SUB;
        end
      end
      SCM_SUB: begin
        osc_stop_nxt = main_osc_stop_bit;
        // relies on software restarting oscillator first
        if (!subclock_select_bit) begin
          // back to normal on main clock
          clk_nxt = SCM_NORMAL;
          osc_stop_nxt = 1'h0;
        end
      end
      default: begin
        clk_nxt = SCM_NORMAL;
      end
    endcase
    if (rpin_fall) begin
      clk_nxt = SCM_NORMAL;
      osc_stop_nxt = 1'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_r <= SCM_NORMAL;
      sw_cnt_r <= 2'h0;
      osc_stop_r <= 1'h0;
    end else begin
      clk_r <= clk_nxt;
      sw_cnt_r <= sw_cnt_nxt;
      osc_stop_r <= osc_stop_nxt;
    end
  end

  // watchdog 1 counter, shared with stabilization timing
  always_comb begin
    cnt_nxt = cnt_r;
    ovf_nxt = 1'h0;
    if (pwr_r == SCM_STOP) begin
      // cleared in stop so the wait starts from zero
      cnt_nxt = {CW{1'h0}};
    end else if (pwr_r == SCM_STAB) begin
      cnt_nxt = cnt_r + CW'(1);
    end else if (clk_r == SCM_SUB) begin
      cnt_nxt = cnt_r;
    end else if (wdt1_clear) begin
      cnt_nxt = {CW{1'h0}};
    end else if (wdt1_run) begin
      cnt_nxt = cnt_r + CW'(1);
      ovf_nxt = cnt_at_ovf;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= {CW{1'h0}};
      ovf_r <= 1'h0;
    end else begin
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // divider copied untouched by mode changes
  always_comb begin
    div_nxt = cpu_clock_divider_field;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= {DW{1'h0}};
    end else begin
      div_r <= div_nxt;
    end
  end

  assign cpu_div_out = div_r;

  assign subclock_status_bit = (clk_r == SCM_SUB);

  assign sys_clk_sel_sub = (clk_r == SCM_SUB);

  // stop always halts the oscillator, whatever the stop bit says
  assign main_osc_en = !osc_stop_r && (pwr_r != SCM_STOP);

  assign in_stop = (pwr_r == SCM_STOP);
  assign stab_wait = (pwr_r == SCM_STAB);
  assign cpu_run = (pwr_r == SCM_RUN);

  assign wdt1_count = cnt_r;
  assign wdt1_overflow = ovf_r;

  // main stopped only counts while in subclock mode
  assign main_stopped = (clk_r == SCM_SUB) && osc_stop_r;

  assign main_periph_en = !main_stopped;

  for (genvar i = 0; i < N_TMR8; i++) begin : g_tmr8
    assign timer8_en[i] = !main_stopped || timer8_ext_clock_sel[i];
  end

  assign interval_timer_h_one_en = !main_stopped || interval_timer_h_one_subclk_sel;
  assign watch_en = !main_stopped || watch_subclk_sel;

  assign wdt2_en = !main_stopped || wdt2_subclk_sel;

  for (genvar j = 0; j < N_CSI; j++) begin : g_csi
    assign csi_en[j] = !main_stopped || csi_ext_clock_sel[j];
  end

  assign uart0_en = !main_stopped || uart0_ext_baud_sel;
endmodule

// ==== test/scm_checker.sv ====
`timescale 1ns/1ps
module scm_checker (
  input logic clk, rst, reset_pin_n, subclock_select_bit,
  input logic main_osc_stop_bit, cpu_run, subclock_status_bit,
  input logic sys_clk_sel_sub, main_osc_en, main_periph_en,
  input logic [19:0] wdt1_count,
  input logic interval_timer_h_one_en, interval_timer_h_one_subclk_sel, watch_en, watch_subclk_sel,
  input logic wdt2_en, wdt2_subclk_sel, uart0_en, uart0_ext_baud_sel,
  input logic wdt1_overflow
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // main clock stopped while on subclock
  wire gate = subclock_status_bit && !main_osc_en;
  sequence s_req;
    !subclock_status_bit && subclock_select_bit && cpu_run && reset_pin_n;
  endsequence
  property p_enter; s_req ##1 s_req |-> ##[1:3] subclock_status_bit; endproperty
  a_enter: assert property (p_enter) else $error("no subclock entry");
  property p_src; subclock_status_bit |-> sys_clk_sel_sub; endproperty
  a_src: assert property (p_src) else $error("clock source wrong");
  property p_mstop;
    subclock_status_bit && subclock_select_bit && main_osc_stop_bit &&
      reset_pin_n |=> !main_osc_en;
  endproperty
  a_mstop: assert property (p_mstop) else $error("osc not halted");
  property p_frz; subclock_status_bit |=> $stable(wdt1_count); endproperty
  a_frz: assert property (p_frz) else $error("wdt1 moved");
  property p_exit;
    subclock_status_bit && !subclock_select_bit |=> !subclock_status_bit;
  endproperty
  a_exit: assert property (p_exit) else $error("no exit");
  property p_norm;
    $fell(subclock_status_bit) |-> !sys_clk_sel_sub && main_osc_en;
  endproperty
  a_norm: assert property (p_norm) else $error("not normal");
  property p_main; main_periph_en == !gate; endproperty
  a_main: assert property (p_main) else $error("main enable");
  property p_h1;
    interval_timer_h_one_en == (!gate || interval_timer_h_one_subclk_sel) &&
      watch_en == (!gate || watch_subclk_sel);
  endproperty
  a_h1: assert property (p_h1) else $error("h1 enable");
  property p_per;
    wdt2_en == (!gate || wdt2_subclk_sel) &&
      uart0_en == (!gate || uart0_ext_baud_sel);
  endproperty
  a_per: assert property (p_per) else $error("wdt2 uart0 enable");
  property p_ovf; wdt1_overflow |-> $past(wdt1_count[9:0]) == 10'h3ff; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow early");
endmodule
bind scm_clock_ctrl scm_checker scm_checker_inst (.*);

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst = 1, reset_pin_n = 1, stop_enter = 0;
  logic stop_wake_irq = 0, subclock_select_bit = 0, main_osc_stop_bit = 0;
  logic wdt1_run = 1, wdt1_clear = 0, interval_timer_h_one_subclk_sel = 0;
  logic watch_subclk_sel = 0, wdt2_subclk_sel = 0, uart0_ext_baud_sel = 0;
  logic [2:0] stab_time_select_reg = 0, cpu_clock_divider_field = 0;
  logic [2:0] csi_ext_clock_sel = 0, cpu_div_out, csi_en;
  logic [1:0] timer8_ext_clock_sel = 0, timer8_en;
  logic subclock_status_bit, sys_clk_sel_sub, main_osc_en, in_stop;
  logic stab_wait, cpu_run, wdt1_overflow, main_periph_en, interval_timer_h_one_en;
  logic watch_en, wdt2_en, uart0_en;
  logic [19:0] wdt1_count, w;
  int err_count = 0, comparisons = 0, seed = 80, n = 0;
  int q[$];
  scm_clock_ctrl scm_clock_ctrl_inst (.*);
  always #20 clk = ~clk;
  task conclude;
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(string s, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s exp %0h got %0h", s, e, g);
    end
  endtask
  task cyc(int k); repeat (k) @(posedge clk); endtask
  task sub_to(logic v);
    for (int i = 0; i < 20 && subclock_status_bit !== v; i++) @(negedge clk);
  endtask
  // wake by irq or by pin; pin wake ignores the programmed select
  task stop_wake(logic [2:0] s, logic pin);
    @(posedge clk) stab_time_select_reg <= s;
    stop_enter <= 1;
    q.push_back(pin ? 32768 : 1 << (10 + s));
    @(posedge clk) stop_enter <= 0;
    cyc(4);
    if (pin) reset_pin_n <= 0; else stop_wake_irq <= 1;
    cyc(6);
    reset_pin_n <= 1;
    stop_wake_irq <= 0;
    for (int i = 0; i < 40000 && (in_stop | stab_wait) !== 0; i++) cyc(1);
  endtask
  // stab length seen as pre-edge samples, free of update races
  always @(posedge clk)
    if (stab_wait === 1) n++;
    else if (n > 0) begin
      chk("stab", q.pop_front(), n);
      n = 0;
    end
  initial begin
    cyc(10);
    rst <= 0;
    cpu_clock_divider_field <= 3'($random(seed));
    cyc(3);
    for (int k = 0; k < 2; k++) stop_wake(3'(k), 0);
    stop_wake(0, 1);
    cyc(50);
    subclock_select_bit <= 1;
    sub_to(1);
    chk("src", 1, sys_clk_sel_sub);
    // divider left alone while the select bit moves
    chk("div", cpu_clock_divider_field, cpu_div_out);
    w = wdt1_count;
    @(posedge clk) main_osc_stop_bit <= 1;
    cyc(20);
    @(negedge clk) chk("wdt1", w, wdt1_count);
    chk("osc", 0, main_osc_en);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk) {timer8_ext_clock_sel, csi_ext_clock_sel, interval_timer_h_one_subclk_sel,
        watch_subclk_sel, wdt2_subclk_sel, uart0_ext_baud_sel} <=
        9'($random(seed));
      @(negedge clk) chk("t8", timer8_ext_clock_sel, timer8_en);
      chk("csi", csi_ext_clock_sel, csi_en);
      chk("main", 0, main_periph_en);
    end
    @(posedge clk) main_osc_stop_bit <= 0;
    cyc(8);
    subclock_select_bit <= 0;
    sub_to(0);
    chk("exit", 0, sys_clk_sel_sub);
    chk("osc", 1, main_osc_en);
    @(posedge clk) subclock_select_bit <= 1;
    sub_to(1);
    @(posedge clk) reset_pin_n <= 0;
    sub_to(0);
    chk("pin", 0, subclock_status_bit);
    @(posedge clk) reset_pin_n <= 1;
    subclock_select_bit <= 0;
    cyc(5);
    chk("left", 0, q.size());
    conclude();
  end
  initial begin
    #3000000;
    err_count++;
    conclude();
  end
endmodule
